// ### verilog/ewc_write_cmd.sv
// Purpose: Device-side extended DMA write command engine with AHB-Lite task file
// Assumes: DMA and media ports run on sys_clk; media acks one sector at a time
// Notes: Reads take one wait state, writes none
// Functional notes
// - Command 35h starts the extended DMA write to media
// - Command 3Dh starts the forced-unit-access variant, otherwise identical
// - Forced variant posts status only after every sector is on media
// - Sector count is previous byte high, current byte low
// - A zero sector count transfers 65,536 sectors
// - Start LBA assembled from current and previous bytes of three registers
// - After failure the failing LBA reads back, HOB picks high bytes
// - Sector data moves in 16-bit words
// - Words move only while the device raises its DMA request
// - One interrupt per command, after transfer ends and status is valid
// - An unrecoverable error stops the write at the failing sector
// - Ending status shows BSY, DF, COR clear; RDY, DSC, ERR valid
// - Normal variant behaves the same except status may precede commit
`timescale 1ns/100ps
module ewc_write_cmd #(
  parameter logic [47:0] MAX_LBA = ewc_pkg::MAX_LBA_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic dmaRq,
  input wire logic dmaWordValid,
  input wire logic [15:0] dmaWord,
  input wire logic dmaCrcErr,
  output logic mediaWordValid,
  output logic [15:0] mediaWord,
  output logic [47:0] mediaLba,
  input wire logic mediaSectorDone,
  input wire logic mediaSectorFail,
  output logic irq
);
  // ==========================================================
  // Types and state
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_XFER = 4'b0010,
    S_WAIT = 4'b0100,
    S_END = 4'b1000
  } ewc_state_t;

  ewc_state_t state_q, state_d;
  logic [15:0] secCnt_q, secNum_q, cylLo_q, cylHi_q;
  logic [7:0] devCtl_q, config_q;
  logic [1:0] intSt_q, intMask_q;
  logic errCrc_q, errIdn_q, errAbt_q, errValid_q, fua_q;
  logic [47:0] failLba_q;
  logic [7:0] wordCnt_q;
  logic wrPend_q, rdPend_q;
  logic [7:0] addr_q;
  logic [31:0] hrdata_q;
  logic mediaWordValid_q;
  logic [15:0] mediaWord_q;
  logic [47:0] curLba;
  logic lastSector;

  // Picks previous or current byte of a task-file pair
  function automatic logic [7:0] pickByte(input logic hob, input logic [15:0] pair);
    pickByte = hob ? pair[15:8] : pair[7:0];
  endfunction

  // Byte register write: old current byte moves to previous
  function automatic logic [15:0] shiftIn(input logic [15:0] pair, input logic [7:0] b);
    shiftIn = {pair[7:0], b};
  endfunction

  // ==========================================================
  // Bus decode
  wire addrPhase = hsel && hready && htrans[1];
  wire wrNow = wrPend_q;
  wire wrSecCnt = wrNow && (addr_q == ewc_pkg::OFF_SECCNT);
  wire wrSecNum = wrNow && (addr_q == ewc_pkg::OFF_SECNUM);
  wire wrCylLo = wrNow && (addr_q == ewc_pkg::OFF_CYLLO);
  wire wrCylHi = wrNow && (addr_q == ewc_pkg::OFF_CYLHI);
  wire wrCmd = wrNow && (addr_q == ewc_pkg::OFF_CMDSTAT);
  wire wrDevCtl = wrNow && (addr_q == ewc_pkg::OFF_DEVCTL);
  wire wrIntSt = wrNow && (addr_q == ewc_pkg::OFF_INTSTAT);
  wire wrIntMask = wrNow && (addr_q == ewc_pkg::OFF_INTMASK);
  wire wrConfig = wrNow && (addr_q == ewc_pkg::OFF_CONFIG);
  wire idle = (state_q == S_IDLE);
  // Task file is frozen while busy so a running command keeps its parameters
  wire tfWrite = idle;

  // ==========================================================
  // Command decode and range check
  wire [15:0] cmdCount = secCnt_q;
  wire [47:0] cmdLba = {cylHi_q[15:8], cylLo_q[15:8], secNum_q[15:8],
                        cylHi_q[7:0], cylLo_q[7:0], secNum_q[7:0]};
  wire [16:0] cmdSectors = (cmdCount == 16'h0000) ? ewc_pkg::ZERO_COUNT_SECTORS : {1'b0, cmdCount};
  wire [48:0] cmdLast = {1'b0, cmdLba} + {32'h0, cmdSectors} - 49'h1;
  wire opNormal = (hwdata[7:0] == ewc_pkg::CMD_WRITE_EXT);
  wire opFua = (hwdata[7:0] == ewc_pkg::CMD_WRITE_FUA_EXT);
  wire cmdAccepted = wrCmd && idle;
  wire cmdKnown = opNormal || opFua;
  wire cmdInRange = (cmdLast <= {1'b0, MAX_LBA});
  wire cmdStart = cmdAccepted && cmdKnown && cmdInRange;
  wire cmdReject = cmdAccepted && !(cmdKnown && cmdInRange);

  // ==========================================================
  // Transfer sequencing
  wire wordTaken = (state_q == S_XFER) && dmaWordValid;
  wire sectorFilled = wordTaken && (wordCnt_q == ewc_pkg::WORDS_PER_SECTOR_M1);
  // Cached normal writes need no media ack before status; forced ones always wait
  wire needCommit = fua_q || !config_q[ewc_pkg::CACHE_EN_BIT];
  wire crcFail = (state_q == S_XFER) && dmaCrcErr;
  wire mediaFail = (state_q == S_WAIT) && mediaSectorFail;
  wire sectorOk = (sectorFilled && !needCommit && !crcFail) ||
                  ((state_q == S_WAIT) && mediaSectorDone && !mediaSectorFail);
  wire trackAdvance = sectorOk && !lastSector;

  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (cmdStart) begin
          state_d = S_XFER;
        end else if (cmdReject) begin
          state_d = S_END;
        end
      end
      S_XFER: begin
        if (crcFail) begin
          state_d = S_END;
        end else if (sectorFilled && needCommit) begin
          state_d = S_WAIT;
        end else if (sectorFilled && lastSector) begin
          state_d = S_END;
        end
      end
      S_WAIT: begin
        if (mediaFail) begin
          state_d = S_END;
        end else if (mediaSectorDone) begin
          state_d = lastSector ? S_END : S_XFER;
        end
      end
      S_END: begin
        state_d = S_IDLE;
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      wordCnt_q <= 8'h00;
      fua_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (cmdStart) begin
        wordCnt_q <= 8'h00;
        fua_q <= opFua;
      end else if (wordTaken) begin
        wordCnt_q <= wordCnt_q + 8'h01;
      end
    end
  end

  ewc_lba_track u_track (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .load(cmdStart),
    .startLba(cmdLba),
    .sectorCount(cmdCount),
    .advance(trackAdvance),
    .curLba(curLba),
    .lastSector(lastSector)
  );

  // ==========================================================
  // Data path toward media
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mediaWordValid_q <= 1'b0;
      mediaWord_q <= 16'h0000;
    end else begin
      mediaWordValid_q <= wordTaken && !crcFail;
      if (wordTaken) begin
        mediaWord_q <= dmaWord;
      end
    end
  end

  assign dmaRq = (state_q == S_XFER);
  assign mediaWordValid = mediaWordValid_q;
  assign mediaWord = mediaWord_q;
  assign mediaLba = curLba;

  // ==========================================================
  // Error capture
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      errCrc_q <= 1'b0;
      errIdn_q <= 1'b0;
      errAbt_q <= 1'b0;
      errValid_q <= 1'b0;
      failLba_q <= 48'h0;
    end else if (cmdAccepted) begin
      errCrc_q <= 1'b0;
      errIdn_q <= cmdKnown && !cmdInRange;
      errAbt_q <= !(cmdKnown && cmdInRange);
      errValid_q <= 1'b0;
    end else if (crcFail || mediaFail) begin
      errCrc_q <= crcFail;
      errAbt_q <= 1'b1;
      errValid_q <= 1'b1;
      failLba_q <= curLba;
    end
  end

  wire anyErr = errCrc_q || errIdn_q || errAbt_q;
  wire [7:0] errorVal = {errCrc_q, 2'b00, errIdn_q, 1'b0, errAbt_q, 2'b00};
  wire [7:0] statusVal = {!idle, 1'b1, 1'b0, 1'b1, 3'b000, anyErr};

  // ==========================================================
  // Task-file registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      secCnt_q <= {2{ewc_pkg::BYTE_RESET}};
      secNum_q <= {2{ewc_pkg::BYTE_RESET}};
      cylLo_q <= {2{ewc_pkg::BYTE_RESET}};
      cylHi_q <= {2{ewc_pkg::BYTE_RESET}};
      devCtl_q <= ewc_pkg::BYTE_RESET;
      config_q <= ewc_pkg::BYTE_RESET;
    end else begin
      if (wrSecCnt && tfWrite) secCnt_q <= shiftIn(secCnt_q, hwdata[7:0]);
      if (wrSecNum && tfWrite) secNum_q <= shiftIn(secNum_q, hwdata[7:0]);
      if (wrCylLo && tfWrite) cylLo_q <= shiftIn(cylLo_q, hwdata[7:0]);
      if (wrCylHi && tfWrite) cylHi_q <= shiftIn(cylHi_q, hwdata[7:0]);
      if (wrDevCtl) devCtl_q <= hwdata[7:0];
      if (wrConfig) config_q <= hwdata[7:0];
    end
  end

  // ==========================================================
  // Interrupts
  wire cmdEnd = (state_q == S_END);
  wire [1:0] intSet = {cmdEnd && anyErr, cmdEnd};
  wire [1:0] intClr = wrIntSt ? hwdata[1:0] : 2'b00;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      intSt_q <= ewc_pkg::INT_RESET;
      intMask_q <= ewc_pkg::INT_RESET;
    end else begin
      intSt_q <= (intSt_q & ~intClr) | intSet;
      if (wrIntMask) intMask_q <= hwdata[1:0];
    end
  end

  assign irq = |(intSt_q & intMask_q);

  // ==========================================================
  // Read mux; failing LBA replaces start LBA once a CRC or media error is recorded
  wire hob = devCtl_q[ewc_pkg::HOB_BIT];
  wire [15:0] numView = errValid_q ? {failLba_q[31:24], failLba_q[7:0]} : secNum_q;
  wire [15:0] loView = errValid_q ? {failLba_q[39:32], failLba_q[15:8]} : cylLo_q;
  wire [15:0] hiView = errValid_q ? {failLba_q[47:40], failLba_q[23:16]} : cylHi_q;
  logic [7:0] rdByte;

  always_comb begin
    case (addr_q)
      ewc_pkg::OFF_SECCNT: rdByte = pickByte(hob, secCnt_q);
      ewc_pkg::OFF_SECNUM: rdByte = pickByte(hob, numView);
      ewc_pkg::OFF_CYLLO: rdByte = pickByte(hob, loView);
      ewc_pkg::OFF_CYLHI: rdByte = pickByte(hob, hiView);
      ewc_pkg::OFF_CMDSTAT: rdByte = statusVal;
      ewc_pkg::OFF_ERROR: rdByte = errorVal;
      ewc_pkg::OFF_DEVCTL: rdByte = devCtl_q;
      ewc_pkg::OFF_INTSTAT: rdByte = {6'h00, intSt_q};
      ewc_pkg::OFF_INTMASK: rdByte = {6'h00, intMask_q};
      ewc_pkg::OFF_CONFIG: rdByte = config_q;
      default: rdByte = 8'h00;
    endcase
  end

  // ==========================================================
  // AHB-Lite slave; one wait state on reads keeps hrdata registered
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_q <= 1'b0;
      rdPend_q <= 1'b0;
      addr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end else begin
      if (rdPend_q) begin
        hrdata_q <= {24'h000000, rdByte};
      end
      if (hreadyout) begin
        wrPend_q <= addrPhase && hwrite;
        rdPend_q <= addrPhase && !hwrite;
        if (addrPhase) addr_q <= haddr[7:0];
      end else begin
        rdPend_q <= 1'b0;
      end
    end
  end

  assign hreadyout = !rdPend_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_start_normal: assert property (cmdAccepted && opNormal && cmdInRange |=> dmaRq && !fua_q)
    else $error("normal write did not start");
  a_start_fua: assert property (cmdAccepted && opFua && cmdInRange |=> dmaRq && fua_q)
    else $error("forced write did not start");
  a_fua_commit: assert property (sectorFilled && fua_q && !crcFail |=> state_q == S_WAIT && !dmaRq)
    else $error("forced write skipped media commit");
  a_zero_count: assert property (cmdStart && cmdCount == 16'h0000 |=> !lastSector)
    else $error("zero count not taken as full range");
  a_fail_lba: assert property (mediaFail |=> errValid_q && failLba_q == $past(curLba))
    else $error("failing LBA not captured");
  a_word_path: assert property (wordTaken && !crcFail |=> mediaWordValid && mediaWord == $past(dmaWord))
    else $error("data word not forwarded");
  a_dmarq_state: assert property ($fell(dmaRq) |-> $past(sectorFilled) || $past(crcFail))
    else $error("request dropped inside a sector");
  a_one_irq: assert property ($rose(intSt_q[ewc_pkg::INT_DONE_BIT]) |-> $past(cmdEnd) && !$past(cmdEnd, 2))
    else $error("completion flag without end of command");
  a_fail_stop: assert property (mediaFail |=> !dmaRq [*4])
    else $error("transfer continued after failure");
  a_err_rsvd: assert property (cmdEnd |-> (errorVal & 8'h6b) == 8'h00 &&
    errorVal[ewc_pkg::ERR_ABT_BIT] == anyErr)
    else $error("reserved error bit set");
  a_end_status: assert property (cmdEnd |=> !statusVal[ewc_pkg::ST_BSY_BIT] && statusVal[ewc_pkg::ST_RDY_BIT])
    else $error("ending status wrong");

  c_fua_done: cover property (cmdStart && opFua ##[1:1000] cmdEnd && !anyErr);
  c_media_fail: cover property (mediaFail);
  c_cached_end: cover property (sectorFilled && !needCommit && lastSector);
  c_reject: cover property (cmdReject);
endmodule

// ### shared/ewc_pkg.sv
// Purpose: Shared constants for the extended DMA write command block
// Assumes: 32-bit AHB-Lite register bus, word aligned registers
// Notes: Offsets are byte addresses
package ewc_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFF_SECCNT = 8'h04;
  localparam logic [7:0] OFF_SECNUM = 8'h08;
  localparam logic [7:0] OFF_CYLLO = 8'h0c;
  localparam logic [7:0] OFF_CYLHI = 8'h10;
  localparam logic [7:0] OFF_CMDSTAT = 8'h14;
  localparam logic [7:0] OFF_ERROR = 8'h18;
  localparam logic [7:0] OFF_DEVCTL = 8'h1c;
  localparam logic [7:0] OFF_INTSTAT = 8'h20;
  localparam logic [7:0] OFF_INTMASK = 8'h24;
  localparam logic [7:0] OFF_CONFIG = 8'h28;
  // ==========================================================
  // Command codes
  localparam logic [7:0] CMD_WRITE_EXT = 8'h35;
  localparam logic [7:0] CMD_WRITE_FUA_EXT = 8'h3d;
  // ==========================================================
  // Field positions
  localparam int HOB_BIT = 7;
  localparam int CACHE_EN_BIT = 0;
  localparam int INT_DONE_BIT = 0;
  localparam int INT_ERR_BIT = 1;
  localparam int ERR_CRC_BIT = 7;
  localparam int ERR_IDN_BIT = 4;
  localparam int ERR_ABT_BIT = 2;
  localparam int ST_BSY_BIT = 7;
  localparam int ST_RDY_BIT = 6;
  localparam int ST_DSC_BIT = 4;
  localparam int ST_ERR_BIT = 0;
  // ==========================================================
  // Counts and reset values
  localparam logic [7:0] WORDS_PER_SECTOR_M1 = 8'hff;
  localparam logic [16:0] ZERO_COUNT_SECTORS = 17'h10000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [1:0] INT_RESET = 2'h0;
  localparam logic [47:0] MAX_LBA_DEFAULT = 48'hffff_ffff_ffff;
endpackage

// ### verilog/ewc_lba_track.sv
// Purpose: Current LBA and remaining sector count of one command
// Assumes: Load and advance never in the same cycle
// Notes: A zero count means the full 16-bit range of 65,536 sectors
`timescale 1ns/100ps
module ewc_lba_track (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [47:0] startLba,
  input wire logic [15:0] sectorCount,
  input wire logic advance,
  output logic [47:0] curLba,
  output logic lastSector
);
  logic [47:0] lba_q;
  logic [16:0] remain_q;
  wire [16:0] loadRemain = (sectorCount == 16'h0000) ? ewc_pkg::ZERO_COUNT_SECTORS : {1'b0, sectorCount};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lba_q <= 48'h0;
      remain_q <= 17'h0;
    end else if (load) begin
      lba_q <= startLba;
      remain_q <= loadRemain;
    end else if (advance) begin
      lba_q <= lba_q + 48'h1;
      remain_q <= remain_q - 17'h1;
    end
  end

  assign curLba = lba_q;
  assign lastSector = (remain_q == 17'h1);
endmodule

// ### tb/ewc_host_model.sv
// Purpose: Host DMA channel and disk media stand-in for the write command engine
// Assumes: Device DMA request is registered, so the word strobe may follow it directly
// Notes: Stalls one cycle in four; media commits each sector six cycles after its last word
`timescale 1ns/100ps
module ewc_host_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic dmaRq,
  input wire logic mediaWordValid,
  input wire logic [15:0] mediaWord,
  input wire logic [47:0] mediaLba,
  input wire logic signed [31:0] failAt,
  output logic dmaWordValid,
  output logic [15:0] dmaWord,
  output logic mediaSectorDone,
  output logic mediaSectorFail,
  output int words,
  output int sectors,
  output int bad,
  output logic [47:0] secLba
);
  // ==========================================================
  // Host side
  logic [1:0] ph_q;
  logic [15:0] cnt_q;
  logic [15:0] exp_q;
  int inSec;
  int dly;
  assign dmaWordValid = dmaRq & (ph_q != 2'h3);
  // Idle data shows the inverse so a stale word never looks valid
  assign dmaWord = dmaWordValid ? cnt_q : ~cnt_q;
  // ==========================================================
  // Media side
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_q <= 2'h0;
      cnt_q <= 16'h1000;
      exp_q <= 16'h1000;
      {words, sectors, bad, inSec, dly} <= '0;
      {mediaSectorDone, mediaSectorFail} <= 2'h0;
      secLba <= 48'h0;
    end else begin
      ph_q <= ph_q + 2'h1;
      if (dmaWordValid) cnt_q <= cnt_q + 16'h1;
      {mediaSectorDone, mediaSectorFail} <= 2'h0;
      if (mediaWordValid) begin
        words <= words + 1;
        exp_q <= exp_q + 16'h1;
        if (mediaWord !== exp_q) bad <= bad + 1;
        if (inSec == 0) secLba <= mediaLba;
        inSec <= (inSec == 255) ? 0 : inSec + 1;
        if (inSec == 255) dly <= 6;
      end
      if (dly > 0) dly <= dly - 1;
      // Commit only after the whole sector arrived
      if (dly == 1 && sectors == failAt) mediaSectorFail <= 1'b1;
      if (dly == 1 && sectors != failAt) begin
        mediaSectorDone <= 1'b1;
        sectors <= sectors + 1;
      end
    end
  end
endmodule

// ### tb/ext_dma_write_command_test.sv
// Purpose: Self-checking bench for the extended DMA write command engine
// Assumes: Write cache enabled only for one normal and one forced run
// Notes: Full 65,536-sector run is too long; zero count is checked through range overflow
`timescale 1ns/100ps
module ext_dma_write_command_test;
  // ==========================================================
  // Signals
  logic sys_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, dmaCrcErr = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0, mask = 2'h0;
  logic hreadyout, hresp, dmaRq, dmaWordValid, mediaWordValid, mediaSectorDone, mediaSectorFail, irq;
  logic [15:0] dmaWord, mediaWord;
  logic [47:0] mediaLba, secLba;
  logic [7:0] v;
  logic [16:0] tbl [13];
  int words, sectors, bad, n_mismatch = 0, num_checks = 0;
  int failAt = -1;
  localparam logic [47:0] LBA = 48'h0605_0403_0201;
  always #2 sys_clk = ~sys_clk;
  ewc_write_cmd #(.MAX_LBA(48'h0605_0403_ffff)) uut (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dmaRq(dmaRq), .dmaWordValid(dmaWordValid),
    .dmaWord(dmaWord), .dmaCrcErr(dmaCrcErr), .mediaWordValid(mediaWordValid), .mediaWord(mediaWord),
    .mediaLba(mediaLba), .mediaSectorDone(mediaSectorDone), .mediaSectorFail(mediaSectorFail), .irq(irq));
  ewc_host_model host (.sys_clk(sys_clk), .rst_n(rst_n), .dmaRq(dmaRq), .mediaWordValid(mediaWordValid),
    .mediaWord(mediaWord), .mediaLba(mediaLba), .failAt(failAt), .dmaWordValid(dmaWordValid),
    .dmaWord(dmaWord), .mediaSectorDone(mediaSectorDone), .mediaSectorFail(mediaSectorFail),
    .words(words), .sectors(sectors), .bad(bad), .secLba(secLba));
  // ==========================================================
  // Tasks
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chkReg(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chkVal(input logic [47:0] g, input logic [47:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Ready is sampled mid-cycle, where the comb path has long settled
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdata);
    logic r;
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do begin @(negedge sys_clk); r = hreadyout; @(posedge sys_clk); end while (r !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(negedge sys_clk); r = hreadyout; rdata = hrdata; @(posedge sys_clk); end while (r !== 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    ahb(1'b1, a, {24'h000000, d}, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    d = x[7:0];
  endtask
  // Previous byte goes first, current byte second
  task automatic setup(input logic [15:0] c, input logic [47:0] l);
    wr(ewc_pkg::OFF_SECCNT, c[15:8]);
    wr(ewc_pkg::OFF_SECCNT, c[7:0]);
    wr(ewc_pkg::OFF_SECNUM, l[31:24]);
    wr(ewc_pkg::OFF_SECNUM, l[7:0]);
    wr(ewc_pkg::OFF_CYLLO, l[39:32]);
    wr(ewc_pkg::OFF_CYLLO, l[15:8]);
    wr(ewc_pkg::OFF_CYLHI, l[47:40]);
    wr(ewc_pkg::OFF_CYLHI, l[23:16]);
  endtask
  task automatic runCmd(input logic [7:0] code, input logic crc, input logic [7:0] st, input logic [7:0] er,
    input logic [1:0] it, input int sec, input int wds, input logic [47:0] lba);
    int s0, w0, k;
    logic [7:0] q;
    s0 = sectors;
    w0 = words;
    wr(ewc_pkg::OFF_CMDSTAT, code);
    if (crc) begin
      k = 0;
      while (dmaRq !== 1'b1 && k < 100) begin @(posedge sys_clk); k++; end
      repeat (3) @(posedge sys_clk);
      dmaCrcErr <= 1'b1;
      @(posedge sys_clk);
      dmaCrcErr <= 1'b0;
    end
    k = 0;
    q = 8'h00;
    while (q === 8'h00 && k < 2000) begin rd(ewc_pkg::OFF_INTSTAT, q); k++; end
    rd(ewc_pkg::OFF_CMDSTAT, q);
    chkReg(q, st);
    rd(ewc_pkg::OFF_ERROR, q);
    chkReg(q, er);
    rd(ewc_pkg::OFF_INTSTAT, q);
    chkReg(q, {6'h00, it});
    chkVal(48'(irq), 48'(|(it & mask)));
    if (!crc) chkVal(48'(sectors - s0), 48'(sec));
    if (!crc) chkVal(48'(words - w0), 48'(wds));
    if (wds > 0) chkVal(secLba, lba);
    wr(ewc_pkg::OFF_INTSTAT, 8'h03);
    repeat (20) @(posedge sys_clk);
    rd(ewc_pkg::OFF_INTSTAT, q);
    chkReg(q, 8'h00);
    chkVal(48'(irq), 48'h0);
  endtask
  // ==========================================================
  // Sequence
  initial begin
    #200000;
    n_mismatch++;
    test_done();
  end
  initial begin
    // Rows: offset, readback select, expected byte
    tbl = '{{8'h04, 1'b0, 8'h02}, {8'h04, 1'b1, 8'h00}, {8'h08, 1'b0, 8'h01}, {8'h08, 1'b1, 8'h04},
      {8'h0c, 1'b0, 8'h02}, {8'h0c, 1'b1, 8'h05}, {8'h10, 1'b0, 8'h03}, {8'h10, 1'b1, 8'h06},
      {8'h14, 1'b0, 8'h50}, {8'h18, 1'b0, 8'h00}, {8'h20, 1'b0, 8'h00}, {8'h28, 1'b0, 8'h00},
      {8'h3c, 1'b0, 8'h00}};
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    chkVal(48'({hreadyout, hresp, irq, dmaRq, mediaWordValid}), 48'h10);
    setup(16'h0002, LBA);
    for (int i = 0; i < 13; i++) begin
      wr(ewc_pkg::OFF_DEVCTL, {tbl[i][8], 7'h00});
      rd(tbl[i][16:9], v);
      chkReg(v, tbl[i][7:0]);
    end
    wr(ewc_pkg::OFF_DEVCTL, 8'h00);
    runCmd(ewc_pkg::CMD_WRITE_EXT, 1'b0, 8'h50, 8'h00, 2'h1, 2, 512, LBA + 48'h1);
    // Cache on: normal run skips commit waits, forced run must still wait
    wr(ewc_pkg::OFF_CONFIG, 8'h01);
    setup(16'h0002, LBA);
    runCmd(ewc_pkg::CMD_WRITE_EXT, 1'b0, 8'h50, 8'h00, 2'h1, 2, 512, LBA + 48'h1);
    mask = 2'h3;
    wr(ewc_pkg::OFF_INTMASK, 8'h03);
    setup(16'h0001, LBA + 48'h5);
    runCmd(ewc_pkg::CMD_WRITE_FUA_EXT, 1'b0, 8'h50, 8'h00, 2'h1, 1, 256, LBA + 48'h5);
    wr(ewc_pkg::OFF_CONFIG, 8'h00);
    failAt = sectors + 1;
    setup(16'h0003, LBA);
    runCmd(ewc_pkg::CMD_WRITE_EXT, 1'b0, 8'h51, 8'h04, 2'h3, 1, 512, LBA + 48'h1);
    failAt = -1;
    for (int h = 0; h < 2; h++) begin
      for (int j = 0; j < 3; j++) begin
        wr(ewc_pkg::OFF_DEVCTL, {h[0], 7'h00});
        rd(8'(8'h08 + 4 * j), v);
        chkReg(v, 8'((LBA + 48'h1) >> (8 * (j + 3 * h))));
      end
    end
    wr(ewc_pkg::OFF_DEVCTL, 8'h00);
    runCmd(8'h30, 1'b0, 8'h51, 8'h04, 2'h3, 0, 0, 48'h0);
    // Zero count means 65,536 sectors, which overruns the top LBA here
    setup(16'h0000, 48'h0605_0403_0001);
    runCmd(ewc_pkg::CMD_WRITE_EXT, 1'b0, 8'h51, 8'h14, 2'h3, 0, 0, 48'h0);
    chkVal(48'(bad), 48'h0);
    // Zero count that just fits is started, then cut short by a link error
    setup(16'h0000, 48'h0605_0403_0000);
    runCmd(ewc_pkg::CMD_WRITE_FUA_EXT, 1'b1, 8'h51, 8'h84, 2'h3, 0, 0, 48'h0);
    test_done();
  end
endmodule
